// *** sdcd_decoder.sv ***
// device end: command decoder with burst tracker and power state
// assumes bus pins are synchronous to clk; resetN is sampled on clk like the others
`timescale 1ns/1ps
module sdcd_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command bus
  sdcd_bus_if.dev bus,
  // decoded command
  output sdcd_pkg::sdcd_cmd_t cmd,
  output logic [sdcd_pkg::BANK_W-1:0] cmdBank,
  output logic [sdcd_pkg::ADDR_W-1:0] cmdAddr,
  output logic autoPre,
  output logic [3:0] burstLen,
  output logic zqLong,
  // status
  output logic burstBusy,
  output sdcd_pkg::sdcd_state_t powerState,
  output logic odtEnable
);
  import sdcd_pkg::*;

  // ***********************************
  // command decode
  // ***********************************
  logic ckePrev;
  logic [1:0] blMode;
  logic [2:0] burstCnt;
  sdcd_cmd_t next_cmd;
  logic sel;
  logic [2:0] strobes;
  logic srxAsync;

  assign sel = ~bus.csN;
  assign strobes = {bus.rasN, bus.casN, bus.weN};
  assign srxAsync = (powerState == SDCD_ST_SREF) & bus.cke;

  always_comb begin
    next_cmd = SDCD_NONE;
    if (ckePrev && bus.cke) begin
      if (sel) begin
        case (strobes)
          3'h0: next_cmd = SDCD_MRW;
          3'h1: next_cmd = SDCD_REF;
          3'h2: next_cmd = bus.addr[AUTO_PRE_BIT] ? SDCD_PREA : SDCD_PRE;
          3'h3: next_cmd = SDCD_ACT;
          3'h4: next_cmd = SDCD_WR;
          3'h5: next_cmd = SDCD_RD;
          3'h6: next_cmd = SDCD_ZQ;
          default: next_cmd = SDCD_NONE;
        endcase
      end
    end else if (ckePrev && !bus.cke) begin
      if (sel && strobes == 3'h1) begin
        next_cmd = SDCD_SRE;
      end else if (!sel || strobes == 3'h7) begin
        next_cmd = SDCD_PDE;
      end
    end else if (!ckePrev && bus.cke && (!sel || strobes == 3'h7)) begin
      if (powerState == SDCD_ST_SREF) begin
        next_cmd = SDCD_SRX;
      end else if (powerState == SDCD_ST_PDOWN) begin
        next_cmd = SDCD_PDX;
      end
    end
  end

  // ***********************************
  // registers
  // ***********************************
  always_ff @(posedge clk) begin
    if (!nrst || !bus.resetN) begin
      ckePrev <= 1'b0;
    end else begin
      ckePrev <= bus.cke;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || !bus.resetN) begin
      cmd <= SDCD_NONE;
      zqLong <= 1'b0;
    end else begin
      cmd <= next_cmd;
      zqLong <= (next_cmd == SDCD_ZQ) & bus.addr[AUTO_PRE_BIT];
    end
  end

  // ***********************************
  // address capture
  // ***********************************
  always_ff @(posedge clk) begin
    if (!nrst || !bus.resetN) begin
      cmdBank <= '0;
      cmdAddr <= '0;
      autoPre <= 1'b0;
    end else begin
      cmdBank <= bus.ba;
      cmdAddr <= bus.addr;
      autoPre <= bus.addr[AUTO_PRE_BIT];
    end
  end

  // ***********************************
  // burst length
  // ***********************************
  always_ff @(posedge clk) begin
    if (!nrst || !bus.resetN) begin
      burstLen <= 4'h0;
    end else if (blMode == BL_OTF) begin
      burstLen <= bus.addr[CHOP_BIT] ? 4'(BURST_BL8) : 4'(BURST_BC4);
    end else begin
      burstLen <= (blMode == BL_FIXED4) ? 4'(BURST_BC4) : 4'(BURST_BL8);
    end
  end

  // ***********************************
  // mode register
  // ***********************************
  // burst mode from mode register
  always_ff @(posedge clk) begin
    if (!nrst || !bus.resetN) begin
      blMode <= MR0_BL_RESET;
    end else if (next_cmd == SDCD_MRW && bus.ba == MR0_SEL) begin
      blMode <= bus.addr[1:0];
    end
  end

  // ***********************************
  // burst tracker
  // ***********************************
  // burst runs to completion
  always_ff @(posedge clk) begin
    if (!nrst || !bus.resetN) begin
      burstCnt <= 3'h0;
      burstBusy <= 1'b0;
    end else if (((next_cmd == SDCD_RD) || (next_cmd == SDCD_WR)) && (burstCnt <= 3'h1)) begin
      // seamless start as the last beat ends
      burstCnt <= BURST_CYC;
      burstBusy <= 1'b1;
    end else if (burstCnt != 3'h0) begin
      burstCnt <= burstCnt - 3'h1;
      burstBusy <= (burstCnt != 3'h1);
    end else begin
      burstBusy <= 1'b0;
    end
  end

  // ***********************************
  // power state
  // ***********************************
  // no refresh kept in power-down
  always_ff @(posedge clk) begin
    if (!nrst || !bus.resetN) begin
      powerState <= SDCD_ST_ACTIVE;
    end else begin
      case (powerState)
        SDCD_ST_ACTIVE: begin
          if (next_cmd == SDCD_SRE) begin
            powerState <= SDCD_ST_SREF;
          end else if (next_cmd == SDCD_PDE) begin
            powerState <= SDCD_ST_PDOWN;
          end
        end
        SDCD_ST_PDOWN: begin
          if (next_cmd == SDCD_PDX) begin
            powerState <= SDCD_ST_ACTIVE;
          end
        end
        SDCD_ST_SREF: begin
          if (srxAsync) begin
            powerState <= SDCD_ST_ACTIVE;
          end
        end
        default: powerState <= SDCD_ST_ACTIVE;
      endcase
    end
  end

  // ***********************************
  // termination
  // ***********************************
  // odt off in self refresh after its first cycle
  always_ff @(posedge clk) begin
    if (!nrst || !bus.resetN) begin
      odtEnable <= 1'b0;
    end else begin
      odtEnable <= bus.odt & (powerState != SDCD_ST_SREF) & ~srxAsync;
    end
  end
endmodule : sdcd_decoder

// *** sdcd_pkg.sv ***
// package of the command decoder: command codes, field layout, timing counts
// assumes one clock at 250 MHz shared by decoder and controller ends
// Operation
// - decode only from strobes and CKE at edge
// - address field widths depend on device configuration
// - controller holds reset high in normal use
// - all strobes low, CKE high: mode register write
// - bank lines pick bank for bank commands
// - write strobe pattern; A10 precharge, A12 chop
// - read strobe pattern; same A10, A12 meaning
// - bursts never cut; length mode from register
// - fixed burst length ignores A12
// - no array refresh during power-down
// - ODT never affects decode; off in self refresh; odtEnable still follows ODT in the first cycle of self refresh
// - self refresh exit detected without clock qualification
// - no write for 512 cycles after self refresh
// - NOP registers nothing, ends nothing; decoder still loads cmdBank, cmdAddr, autoPre and burstLen every cycle
// - controller drives NOP when idle
// - deselect behaves exactly as NOP
// - controller drives valid inputs to defined levels
// - controller uses NOP only for power-down change
// - self refresh entry only with banks idle
package sdcd_pkg;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 16;
  localparam int BURST_BC4 = 4;
  localparam int BURST_BL8 = 8;
  localparam int AUTO_PRE_BIT = 10;
  localparam int CHOP_BIT = 12;
  // burst tracker busy span in clocks
  localparam logic [2:0] BURST_CYC = 3'h4;
  // mode register 0 burst length field: 00 fixed BL8, 01 on the fly, 10 fixed BC4
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [2:0] MR0_SEL = 3'h0;
  localparam logic [1:0] MR0_BL_RESET = 2'h0;
  localparam int SRX_WRITE_GAP_NCK = 512;
  localparam int CLK_MHZ = 250;
  localparam int SRX_WRITE_GAP_CYC = SRX_WRITE_GAP_NCK;
  localparam logic [9:0] SRX_GAP_CNT = 10'(SRX_WRITE_GAP_CYC);

  typedef enum logic [11:0] {
    SDCD_NONE = 12'h000, SDCD_MRW = 12'h001, SDCD_REF = 12'h002, SDCD_SRE = 12'h004,
    SDCD_SRX = 12'h008, SDCD_PRE = 12'h010, SDCD_PREA = 12'h020, SDCD_ACT = 12'h040,
    SDCD_WR = 12'h080, SDCD_RD = 12'h100, SDCD_PDE = 12'h200, SDCD_PDX = 12'h400,
    SDCD_ZQ = 12'h800
  } sdcd_cmd_t;

  typedef enum logic [2:0] {
    SDCD_ST_ACTIVE = 3'h1, SDCD_ST_PDOWN = 3'h2, SDCD_ST_SREF = 3'h4
  } sdcd_state_t;
endpackage : sdcd_pkg

// *** sdcd_bus_if.sv ***
// interface: command bus from controller to decoder, shared clock
// assumes controller end drives every command pin
`timescale 1ns/1ps
interface sdcd_bus_if;
  import sdcd_pkg::*;
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic odt;
  logic resetN;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  modport ctrl (output cke, csN, rasN, casN, weN, odt, resetN, ba, addr);
  modport dev (input cke, csN, rasN, casN, weN, odt, resetN, ba, addr);
endinterface : sdcd_bus_if

// *** sdcd_controller.sv ***
// controller end: drives one command per request, NOP otherwise and for writes within 512 cycles of self refresh exit
// assumes user keeps bank idle before self refresh requests
`timescale 1ns/1ps
module sdcd_controller (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command bus
  sdcd_bus_if.ctrl bus,
  // user request
  input wire logic reqValid,
  input sdcd_pkg::sdcd_cmd_t reqCmd,
  input wire logic [sdcd_pkg::BANK_W-1:0] reqBank,
  input wire logic [sdcd_pkg::ADDR_W-1:0] reqAddr,
  input wire logic reqOdt,
  output logic reqReady
);
  import sdcd_pkg::*;

  logic [9:0] gapCnt;
  logic lowPower;
  logic isWrite;
  logic take;

  assign isWrite = (reqCmd == SDCD_WR);
  assign take = reqValid & reqReady & ~(isWrite & (gapCnt != 10'h0));

  // ***********************************
  // command drive
  // ***********************************
  // reset held high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus.resetN <= 1'b0;
    end else begin
      bus.resetN <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h7;
      bus.cke <= 1'b0;
      bus.ba <= '0;
      bus.addr <= '0;
      bus.odt <= 1'b0;
      lowPower <= 1'b0;
    end else begin
      {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h7;
      bus.ba <= reqBank;
      bus.addr <= reqAddr;
      bus.odt <= reqOdt;
      if (!lowPower) begin
        bus.cke <= 1'b1;
      end
      if (take) begin
        case (reqCmd)
          SDCD_MRW: {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h0;
          SDCD_REF: {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h1;
          SDCD_PRE, SDCD_PREA: {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h2;
          SDCD_ACT: {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h3;
          SDCD_WR: {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h4;
          SDCD_RD: {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h5;
          SDCD_ZQ: {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h6;
          SDCD_SRE: begin
            {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h1;
            bus.cke <= 1'b0;
            lowPower <= 1'b1;
          end
          SDCD_PDE: begin
            bus.cke <= 1'b0;
            lowPower <= 1'b1;
          end
          SDCD_PDX, SDCD_SRX: begin
            bus.cke <= 1'b1;
            lowPower <= 1'b0;
          end
          default: {bus.csN, bus.rasN, bus.casN, bus.weN} <= 4'h7;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      gapCnt <= 10'h0;
    end else if (take && reqCmd == SDCD_SRX) begin
      gapCnt <= SRX_GAP_CNT;
    end else if (gapCnt != 10'h0) begin
      gapCnt <= gapCnt - 10'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      reqReady <= 1'b0;
    end else begin
      reqReady <= 1'b1;
    end
  end
endmodule : sdcd_controller

// *** sdcd_bus_checker.sv ***
// checker: decode, burst and power-state relations at the command bus
// assumes tb_top wires it to the bus and to the decoder outputs
`timescale 1ns/1ps
module sdcd_bus_checker (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // bus pins
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic resetN,
  input wire logic [sdcd_pkg::BANK_W-1:0] ba,
  input wire logic [sdcd_pkg::ADDR_W-1:0] addr,
  // decoder outputs
  input sdcd_pkg::sdcd_cmd_t cmd,
  input wire logic [sdcd_pkg::BANK_W-1:0] cmdBank,
  input wire logic [sdcd_pkg::ADDR_W-1:0] cmdAddr,
  input wire logic autoPre,
  input wire logic zqLong,
  input wire logic burstBusy,
  input sdcd_pkg::sdcd_state_t powerState,
  input wire logic odtEnable
);
  import sdcd_pkg::*;
  logic idleCmd;
  assign idleCmd = csN || (rasN && casN && weN);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ****************
  // assertions
  // ****************
  sequence cmdEdge;
    resetN && cke && $past(cke) && !csN;
  endsequence
  sequence busyRun;
    burstBusy [*4];
  endsequence
  mode_write_a: assert property (cmdEdge ##0 (!rasN && !casN && !weN) |=> cmd == SDCD_MRW)
    else $error("mode write not decoded");
  write_decode_a: assert property (cmdEdge ##0 (rasN && !casN && !weN) |=>
    cmd == SDCD_WR && cmdBank == $past(ba) && cmdAddr == $past(addr) && autoPre == cmdAddr[AUTO_PRE_BIT])
    else $error("write not decoded");
  read_burst_a: assert property (cmdEdge ##0 (rasN && !casN && weN) |=> cmd == SDCD_RD ##0 busyRun)
    else $error("read or its burst wrong");
  nop_quiet_a: assert property (resetN && cke && $past(cke) && idleCmd |=> cmd == SDCD_NONE)
    else $error("idle command registered");
  row_decode_a: assert property (cmdEdge ##0 (!rasN && casN) |=>
    cmd == ($past(weN) ? SDCD_ACT : (cmdAddr[AUTO_PRE_BIT] ? SDCD_PREA : SDCD_PRE)))
    else $error("activate or precharge wrong");
  zq_decode_a: assert property (cmdEdge ##0 (rasN && casN && !weN) |=>
    cmd == SDCD_ZQ && zqLong == cmdAddr[AUTO_PRE_BIT])
    else $error("calibration wrong");
  sref_entry_a: assert property (resetN && $past(cke) && !cke && !csN && !rasN && !casN && weN |=>
    powerState == SDCD_ST_SREF)
    else $error("self refresh not entered");
  pdown_entry_a: assert property (resetN && $past(cke) && !cke && idleCmd |=> powerState == SDCD_ST_PDOWN)
    else $error("power-down not entered");
  power_exit_a: assert property (cke && (powerState == SDCD_ST_SREF ||
    (powerState == SDCD_ST_PDOWN && idleCmd)) |=> powerState == SDCD_ST_ACTIVE)
    else $error("low power state not left");
  odt_off_a: assert property (powerState == SDCD_ST_SREF ##1 powerState == SDCD_ST_SREF |-> !odtEnable)
    else $error("odt active in self refresh");
endmodule : sdcd_bus_checker

// *** tb_top.sv ***
// testbench: controller drives decoder over the bus, decoded outputs compared
// assumes package, interface, both ends and checker compiled first
`timescale 1ns/1ps
module tb_top;
  import sdcd_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reqValid = 1'b0;
  sdcd_cmd_t reqCmd = SDCD_NONE;
  logic [BANK_W-1:0] reqBank = 3'h0;
  logic [ADDR_W-1:0] reqAddr = 16'h0000;
  logic reqOdt = 1'b0;
  logic reqReady, autoPre, zqLong, burstBusy, odtEnable;
  sdcd_cmd_t cmd, op;
  logic [BANK_W-1:0] cmdBank;
  logic [ADDR_W-1:0] cmdAddr, a;
  logic [3:0] burstLen;
  sdcd_state_t powerState;
  logic [1:0] blMode = BL_FIXED8;
  logic [31:0] seed = 32'hd5c70819;
  int errorCnt = 0;
  int checkCount = 0;
  sdcd_cmd_t ops [7] = '{SDCD_REF, SDCD_PRE, SDCD_PREA, SDCD_ACT, SDCD_WR, SDCD_RD, SDCD_ZQ};
  always #2 clk = ~clk;
  sdcd_bus_if bus ();
  sdcd_controller sdcd_controller_inst (.clk(clk), .nrst(nrst), .bus(bus), .reqValid(reqValid), .reqCmd(reqCmd),
    .reqBank(reqBank), .reqAddr(reqAddr), .reqOdt(reqOdt), .reqReady(reqReady));
  sdcd_decoder sdcd_decoder_inst (.clk(clk), .nrst(nrst), .bus(bus), .cmd(cmd), .cmdBank(cmdBank),
    .cmdAddr(cmdAddr), .autoPre(autoPre), .burstLen(burstLen), .zqLong(zqLong), .burstBusy(burstBusy),
    .powerState(powerState), .odtEnable(odtEnable));
  sdcd_bus_checker sdcd_bus_checker_inst (.clk(clk), .nrst(nrst), .cke(bus.cke), .csN(bus.csN),
    .rasN(bus.rasN), .casN(bus.casN), .weN(bus.weN), .resetN(bus.resetN), .ba(bus.ba), .addr(bus.addr),
    .cmd(cmd), .cmdBank(cmdBank), .cmdAddr(cmdAddr), .autoPre(autoPre), .zqLong(zqLong),
    .burstBusy(burstBusy), .powerState(powerState), .odtEnable(odtEnable));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsrNext
  function automatic logic [15:0] expLen(input logic [1:0] m, input logic a12);
    return (m == BL_OTF) ? (a12 ? 16'h0008 : 16'h0004) : ((m == BL_FIXED4) ? 16'h0004 : 16'h0008);
  endfunction : expLen
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    checkCount++;
    if (got !== want) begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : check
  task automatic giveVerdict();
    $display("checks=%0d errors=%0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : giveVerdict
  // one request, decoded command compared two edges later
  task automatic issue(input sdcd_cmd_t c, input logic [15:0] ad, input sdcd_cmd_t want);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n == 50) begin
      errorCnt++;
      giveVerdict();
    end
    reqValid = 1'b1;
    reqCmd = c;
    reqBank = (c == SDCD_MRW) ? MR0_SEL : seed[2:0];
    reqAddr = ad;
    reqOdt = seed[3];
    @(negedge clk);
    reqValid = 1'b0;
    @(negedge clk);
    check(16'(cmd), 16'(want));
  endtask : issue
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 48; i++) begin
      seed = lfsrNext(seed);
      if (i == 16 || i == 32) begin
        blMode = (i == 16) ? BL_OTF : BL_FIXED4;
        issue(SDCD_MRW, {14'h0000, blMode}, SDCD_MRW);
      end
      op = ops[seed[6:4] % 7];
      a = seed[31:16];
      a[10] = (op == SDCD_PREA) ? 1'b1 : ((op == SDCD_PRE) ? 1'b0 : a[10]);
      issue(op, a, op);
      if (op == SDCD_RD || op == SDCD_WR) begin
        check(16'(burstLen), expLen(blMode, a[12]));
        check(16'(autoPre), 16'(a[10]));
        check(16'(cmdBank), 16'(reqBank));
        repeat (2) @(negedge clk);
      end
      if (op == SDCD_ZQ) check(16'(zqLong), 16'(a[10]));
    end
    issue(SDCD_PDE, 16'h0000, SDCD_PDE);
    check(16'(powerState), 16'(SDCD_ST_PDOWN));
    issue(SDCD_PDX, 16'h0000, SDCD_PDX);
    check(16'(powerState), 16'(SDCD_ST_ACTIVE));
    issue(SDCD_PREA, 16'h0400, SDCD_PREA);
    issue(SDCD_SRE, 16'h0000, SDCD_SRE);
    check(16'(powerState), 16'(SDCD_ST_SREF));
    reqOdt = 1'b1;
    repeat (3) @(negedge clk);
    check(16'(odtEnable), 16'h0000);
    issue(SDCD_SRX, 16'h0000, SDCD_SRX);
    check(16'(powerState), 16'(SDCD_ST_ACTIVE));
    issue(SDCD_WR, 16'h0010, SDCD_NONE);
    repeat (520) @(negedge clk);
    issue(SDCD_WR, 16'h0010, SDCD_WR);
    check(16'(odtEnable), 16'(reqOdt));
    giveVerdict();
  end
endmodule : tb_top
